/* File: ddr_port_pkg.sv */
// Purpose: shared constants and carriers for the two-word burst sram port
// Assumes: core clock of 100 MHz, x18 organisation (set data_w to 8 for x8)
// Notes: lanes are data_w/2 bits wide, one select per lane
package ddr_port_pkg;
  // array organisation
  localparam int ADDR_W = 21;
  localparam int DATA_W = 18;
  localparam int LANES = 2;
  localparam int LANE_W = DATA_W / LANES;
  localparam int DEPTH = 1 << ADDR_W;
  // core clock and timing figures
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOCK_US = 20;
  localparam int LOCK_CYC = (LOCK_US * 1000) / CLK_PERIOD_NS;
  localparam int STOP_NS = 30;
  localparam int STOP_CYC = (STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ZQ_PERIOD_CYC = 1024;
  localparam int LOCK_CNT_W = 12;
  localparam int STOP_CNT_W = 2;
  localparam int ZQ_CNT_W = 10;
  // reset values
  localparam logic RST_LOW = 1'h0;

  // read pipeline stage
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } rd_stage_t;

  // first half of a write burst
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] mask_n;
  } wr_stage_t;
endpackage

/* File: ddr_sram_port.sv */
// Purpose: synchronous port of a separate read/write ddr burst sram
// Assumes: link_clk_i is the true input clock, its falling edge stands for the complement rise
// Notes: output registers run from the input pair, as with zero skew to the output clocks
`timescale 1ns/100ps

// Summary of operation
// - output clock pins both high from power-on select single-clock mode
// - single-clock mode times outputs from the input clock pair, timing unchanged
// - single-clock choice caught once after reset, never changes later
// - read and write ports run independently, both may start each cycle
// - reads return newest data, including the write of the previous cycle
// - port selects are sampled only on the true input clock rise
// - deselecting a port leaves the other alone; pending bursts finish
// - output impedance recalibrated every 1024 cycles after reset
// - two free-running echo clocks follow the output clock phases
// - pll locks 20 us after a stable input clock appears
// - input clock stopped 30 ns or more resets the pll, then relock
// - pll disabled gives one-cycle read latency instead of one and a half
// - write: select low at rise latches first word, second on complement rise
// - read: first word at complement rise t+1, second at true rise t+2
// - x18: select 0 writes bits 8:0, select 1 writes bits 17:9
// - x8: select 0 writes bits 3:0, select 1 writes bits 7:4
// - all masks high at a burst half store nothing for that word
// - after reset both ports idle and read data outputs released
// - outputs release after the output clock rise following the last word
module ddr_sram_port (
  input wire logic clk_i, // core clock
  input wire logic reset_n_i, // asynchronous reset
  input wire logic link_clk_i, // true input clock
  input wire logic [1:0] output_clk_i, // output clock pair, strap only
  input wire logic pll_enable_strap_i, // high enables the pll
  input wire logic [ddr_port_pkg::ADDR_W-1:0] addr_i, // shared address bus
  input wire logic [ddr_port_pkg::DATA_W-1:0] write_data_i, // write data
  input wire logic [ddr_port_pkg::LANES-1:0] byte_write_select_n_i, // lane masks
  input wire logic read_port_select_n_i, // read select
  input wire logic write_port_select_n_i, // write select
  output logic [ddr_port_pkg::DATA_W-1:0] read_data_o, // read data
  output logic read_data_oe_n_o, // low while read data is driven
  output logic [1:0] echo_clock_o, // true and complement echo clocks
  output logic pll_locked_o, // pll lock status
  output logic impedance_update_o, // one-cycle recalibration strobe
  output logic single_clock_mode_o // strapped single-clock mode
);

  // masked merge of one burst word, one select per lane
  function automatic logic [ddr_port_pkg::DATA_W-1:0] merge(
    input logic [ddr_port_pkg::DATA_W-1:0] old_word,
    input logic [ddr_port_pkg::DATA_W-1:0] new_word,
    input logic [ddr_port_pkg::LANES-1:0] mask_n);
    logic [ddr_port_pkg::DATA_W-1:0] r;
    r = old_word;
    for (int b = 0; b < ddr_port_pkg::DATA_W; b++) begin
      if (!mask_n[b / ddr_port_pkg::LANE_W]) begin
        r[b] = new_word[b];
      end
    end
    return r;
  endfunction

  // link domain state
  logic link_rst_meta;
  logic link_rst_n;
  logic pll_meta;
  logic lat15;
  ddr_port_pkg::rd_stage_t rd1;
  ddr_port_pkg::rd_stage_t rd2;
  ddr_port_pkg::wr_stage_t wr;
  logic p_tog;
  logic n_tog;
  logic p_drive;
  logic n_drive;
  logic [ddr_port_pkg::DATA_W-1:0] p_word;
  logic [ddr_port_pkg::DATA_W-1:0] n_word;
  logic [ddr_port_pkg::DATA_W-1:0] mem_lo [ddr_port_pkg::DEPTH];
  logic [ddr_port_pkg::DATA_W-1:0] mem_hi [ddr_port_pkg::DEPTH];

  // core domain state
  logic [1:0] oclk_meta;
  logic [1:0] oclk_sync;
  logic pll_c_meta;
  logic pll_c_sync;
  logic k_meta;
  logic k_sync;
  logic k_prev;
  logic strap_done;
  logic [1:0] strap_wait;
  logic [ddr_port_pkg::STOP_CNT_W-1:0] stop_cnt;
  logic [ddr_port_pkg::LOCK_CNT_W-1:0] lock_cnt;
  logic [ddr_port_pkg::ZQ_CNT_W-1:0] zq_cnt;

  // link reset: asynchronous assert, release synchronised to the input clock
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link_rst_meta <= ddr_port_pkg::RST_LOW;
      link_rst_n <= ddr_port_pkg::RST_LOW;
    end else begin
      link_rst_meta <= 1'h1;
      link_rst_n <= link_rst_meta;
    end
  end

  // request decode; both selects high means a nop
  wire rd_start = !read_port_select_n_i;
  wire wr_start = !write_port_select_n_i;
  wire [ddr_port_pkg::ADDR_W-1:0] p_addr = lat15 ? rd2.addr : rd1.addr;
  wire next_p_drive = lat15 ? rd2.valid : rd1.valid;
  wire [ddr_port_pkg::DATA_W-1:0] next_p_word = lat15 ? mem_hi[p_addr] : mem_lo[p_addr];
  wire next_n_drive = rd2.valid;
  wire [ddr_port_pkg::DATA_W-1:0] next_n_word = lat15 ? mem_lo[rd2.addr] : mem_hi[rd2.addr];

  // true clock rise: latch selects, read address, first write word
  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pll_meta <= ddr_port_pkg::RST_LOW;
      lat15 <= ddr_port_pkg::RST_LOW;
      rd1 <= '0;
      rd2 <= '0;
      wr <= '0;
      p_tog <= ddr_port_pkg::RST_LOW;
      p_drive <= ddr_port_pkg::RST_LOW;
      p_word <= '0;
    end else begin
      pll_meta <= pll_enable_strap_i;
      lat15 <= pll_meta;
      rd1 <= '{valid: rd_start, addr: addr_i};
      rd2 <= rd1;
      wr <= '{valid: wr_start, data: write_data_i, mask_n: byte_write_select_n_i};
      p_tog <= n_tog;
      p_drive <= next_p_drive;
      p_word <= next_p_word;
    end
  end

  // complement clock rise: read word (first with pll on, second with pll off) and release
  always_ff @(negedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      n_tog <= ddr_port_pkg::RST_LOW;
      n_drive <= ddr_port_pkg::RST_LOW;
      n_word <= '0;
    end else begin
      n_tog <= ~p_tog;
      n_drive <= next_n_drive;
      n_word <= next_n_word;
    end
  end

  // write commit at the complement rise, address and second word taken here
  always_ff @(negedge link_clk_i) begin
    if (wr.valid) begin
      mem_lo[addr_i] <= merge(mem_lo[addr_i], wr.data, wr.mask_n);
      mem_hi[addr_i] <= merge(mem_hi[addr_i], write_data_i, byte_write_select_n_i);
    end
  end

  // pick the register of the latest edge; echo clocks follow the same phase
  wire last_neg = p_tog ^ n_tog;
  assign read_data_o = last_neg ? n_word : p_word;
  assign read_data_oe_n_o = ~(last_neg ? n_drive : p_drive);
  assign echo_clock_o = {last_neg, ~last_neg};

  // core domain: synchronisers for pins and input clock activity
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oclk_meta <= '0;
      oclk_sync <= '0;
      pll_c_meta <= ddr_port_pkg::RST_LOW;
      pll_c_sync <= ddr_port_pkg::RST_LOW;
      k_meta <= ddr_port_pkg::RST_LOW;
      k_sync <= ddr_port_pkg::RST_LOW;
      k_prev <= ddr_port_pkg::RST_LOW;
    end else begin
      oclk_meta <= output_clk_i;
      oclk_sync <= oclk_meta;
      pll_c_meta <= pll_enable_strap_i;
      pll_c_sync <= pll_c_meta;
      k_meta <= p_tog;
      k_sync <= k_meta;
      k_prev <= k_sync;
    end
  end

  // strap capture once after release, only when both synchroniser flops hold the pins;
  // capturing at the first edge would latch the reset value of the synchroniser instead
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_wait <= '0;
      strap_done <= ddr_port_pkg::RST_LOW;
      single_clock_mode_o <= ddr_port_pkg::RST_LOW;
    end else if (!strap_done) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        strap_done <= 1'h1;
        single_clock_mode_o <= &oclk_sync;
      end
    end
  end

  // pll model: stall detector and lock timer
  wire k_stopped = (stop_cnt == ddr_port_pkg::STOP_CNT_W'(ddr_port_pkg::STOP_CYC));
  wire lock_full = (lock_cnt == ddr_port_pkg::LOCK_CNT_W'(ddr_port_pkg::LOCK_CYC));
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stop_cnt <= '0;
      lock_cnt <= '0;
      pll_locked_o <= ddr_port_pkg::RST_LOW;
    end else begin
      if (k_sync != k_prev) begin
        stop_cnt <= '0;
      end else if (!k_stopped) begin
        stop_cnt <= stop_cnt + 1'b1;
      end
      if (!pll_c_sync || k_stopped) begin
        lock_cnt <= '0;
      end else if (!lock_full) begin
        lock_cnt <= lock_cnt + 1'b1;
      end
      pll_locked_o <= pll_c_sync && !k_stopped && lock_full;
    end
  end

  // impedance recalibration strobe
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      zq_cnt <= '0;
      impedance_update_o <= ddr_port_pkg::RST_LOW;
    end else begin
      zq_cnt <= zq_cnt + 1'b1;
      impedance_update_o <= (zq_cnt == ddr_port_pkg::ZQ_CNT_W'(ddr_port_pkg::ZQ_PERIOD_CYC - 1));
    end
  end

  // checks
  write_start_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
    !write_port_select_n_i |=> wr.valid && wr.data == $past(write_data_i))
    else $error("write start not latched");
  nop_idle_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
    (read_port_select_n_i && write_port_select_n_i) |=> !rd1.valid && !wr.valid)
    else $error("nop started an operation");
  port_indep_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
    (!read_port_select_n_i && !write_port_select_n_i) |=> rd1.valid && wr.valid ##1 rd2.valid)
    else $error("concurrent read and write not both started");
  read_latency_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
    (lat15 && !read_port_select_n_i) ##1 lat15 |=> p_drive == 1'h0 || rd2.addr == $past(addr_i, 2))
    else $error("read address lost in pipeline");
  out_release_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
    (lat15 && !read_port_select_n_i) ##1 (lat15 && read_port_select_n_i) ##1 lat15
      |=> p_drive ##1 !p_drive)
    else $error("read outputs not released after burst");
  strap_fixed_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    strap_done |=> $stable(single_clock_mode_o))
    else $error("single clock strap changed");
  lock_time_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(pll_locked_o) |-> $past(lock_cnt) == ddr_port_pkg::LOCK_CNT_W'(ddr_port_pkg::LOCK_CYC))
    else $error("pll locked early");
  pll_reset_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    k_stopped |=> !pll_locked_o ##1 lock_cnt == '0 || !k_stopped)
    else $error("pll not reset by stopped clock");
  zq_period_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    impedance_update_o |=> !impedance_update_o [*8])
    else $error("impedance strobe too frequent");

  // link side: request capture and pipeline progress
  read_addr_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
    !read_port_select_n_i |=> rd1.valid && rd1.addr == $past(addr_i))
    else $error("read address not latched");
  read_finish_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
    rd1.valid |=> rd2.valid)
    else $error("pending read dropped");
  write_mask_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
    !write_port_select_n_i |=> wr.mask_n == $past(byte_write_select_n_i))
    else $error("first word mask not latched");
  short_latency_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
    (!lat15 && !read_port_select_n_i) ##1 !lat15 |=> p_drive)
    else $error("one cycle read word missing");

  // link side: echo clock phase and idle outputs
  echo_rise_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
    echo_clock_o == 2'h2)
    else $error("echo clock wrong before true rise");
  echo_fall_a: assert property (@(negedge link_clk_i) disable iff (!link_rst_n)
    echo_clock_o == 2'h1)
    else $error("echo clock wrong before complement rise");
  reset_idle_a: assert property (@(posedge link_clk_i)
    !link_rst_n |-> read_data_oe_n_o)
    else $error("read outputs driven in reset");

  // core side: lock drop and impedance timing
  lock_drop_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !pll_c_sync |=> !pll_locked_o)
    else $error("lock shown with pll disabled");
  zq_point_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    impedance_update_o |-> $past(zq_cnt) == ddr_port_pkg::ZQ_CNT_W'(ddr_port_pkg::ZQ_PERIOD_CYC - 1))
    else $error("impedance strobe off period");

  // coverage of the main scenarios
  cov_rw_c: cover property (@(posedge link_clk_i) disable iff (!link_rst_n)
    !read_port_select_n_i && !write_port_select_n_i);
  cov_b2b_c: cover property (@(posedge link_clk_i) disable iff (!link_rst_n)
    !read_port_select_n_i ##1 !read_port_select_n_i);
  cov_lock_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(pll_locked_o));
  cov_mask_c: cover property (@(posedge link_clk_i) disable iff (!link_rst_n)
    wr.valid && &wr.mask_n);
endmodule

/* File: ctrl_model.sv */
// Purpose: controller model for the link side of the sram port
// Assumes: free-running 6 ns link clock, stopped only for a pll reset
// Notes: lines not in use toggle so a stale value never passes
`timescale 1ns/100ps
module ctrl_model (
  input wire logic run_i, // link clock enable
  output logic link_clk_o, // link clock
  output logic [ddr_port_pkg::ADDR_W-1:0] addr_o, // address
  output logic [ddr_port_pkg::DATA_W-1:0] data_o, // write data
  output logic [1:0] mask_n_o, // lane masks
  output logic rd_sel_n_o, // read select
  output logic wr_sel_n_o // write select
);
  // link clock, held still while run_i is low
  initial begin
    link_clk_o = 1'h0;
    addr_o = '0;
    data_o = '0;
    mask_n_o = 2'h3;
    rd_sel_n_o = 1'h1;
    wr_sel_n_o = 1'h1;
    #1.7;
    forever begin
      #3;
      if (run_i) begin
        link_clk_o = ~link_clk_o;
      end
    end
  end

  // one link cycle: rise-sampled fields, then fall-sampled ones
  task automatic cyc(input logic rd, input logic [ddr_port_pkg::ADDR_W-1:0] ra, input logic wr,
    input logic [ddr_port_pkg::ADDR_W-1:0] wa, input logic [ddr_port_pkg::DATA_W-1:0] w0, w1,
    input logic [1:0] m0, m1);
    @(negedge link_clk_o);
    #0.5;
    rd_sel_n_o = ~rd;
    wr_sel_n_o = ~wr;
    addr_o = rd ? ra : ~addr_o;
    data_o = wr ? w0 : ~data_o;
    mask_n_o = wr ? m0 : ~mask_n_o;
    @(posedge link_clk_o);
    #0.5;
    rd_sel_n_o = 1'h1;
    wr_sel_n_o = 1'h1;
    addr_o = wr ? wa : ~addr_o;
    data_o = wr ? w1 : ~data_o;
    mask_n_o = wr ? m1 : ~mask_n_o;
  endtask
endmodule

/* File: ddr_sram_port_tb.sv */
// Purpose: self-checking bench for the ddr sram port
// Assumes: single-clock strap, eight addresses in play, fixed seed
// Notes: a shadow array with forwarding predicts every read word
`timescale 1ns/100ps
module ddr_sram_port_tb;
  localparam int DW = ddr_port_pkg::DATA_W;
  localparam int LC = ddr_port_pkg::LOCK_CYC;
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic pll_en = 1'h1;
  logic run = 1'h1;
  logic chk = 1'h0;
  logic seen = 1'h0;
  logic k, rsel_n, wsel_n, oe_n, locked, imp_upd, single;
  logic [1:0] mask_n, echo;
  logic [ddr_port_pkg::ADDR_W-1:0] addr;
  logic [DW-1:0] wdata, rdata;
  logic [2*DW-1:0] mem [int];
  logic [2*DW-1:0] nxt_e;
  logic [2*DW-1:0] e [3];
  logic [2:0] v = 3'h0;
  int gap = 0;
  int miscompares = 0;
  int tests_run = 0;

  ctrl_model u_ctrl (.run_i(run), .link_clk_o(k), .addr_o(addr), .data_o(wdata), .mask_n_o(mask_n),
    .rd_sel_n_o(rsel_n), .wr_sel_n_o(wsel_n));
  ddr_sram_port DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .link_clk_i(k), .output_clk_i(2'h3),
    .pll_enable_strap_i(pll_en), .addr_i(addr), .write_data_i(wdata), .byte_write_select_n_i(mask_n),
    .read_port_select_n_i(rsel_n), .write_port_select_n_i(wsel_n), .read_data_o(rdata),
    .read_data_oe_n_o(oe_n), .echo_clock_o(echo), .pll_locked_o(locked),
    .impedance_update_o(imp_upd), .single_clock_mode_o(single));

  // core clock
  initial forever #5 clk_i = ~clk_i;

  task automatic check(input logic [2*DW-1:0] got, input logic [2*DW-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h, expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [20:0] adr(input int i);
    return (i == 7) ? 21'h1f_ffff : 21'(i);
  endfunction

  // a high mask keeps the stored lane
  function automatic logic [DW-1:0] mrg(input logic [DW-1:0] o, n, input logic [1:0] m);
    return {m[1] ? o[17:9] : n[17:9], m[0] ? o[8:0] : n[8:0]};
  endfunction

  // one link cycle with the shadow array updated first
  task automatic op(input logic rd, input int ri, input logic wr, input int wi, input logic [1:0] m0, m1);
    logic [DW-1:0] w0, w1;
    logic [2*DW-1:0] old;
    w0 = DW'($urandom);
    w1 = DW'($urandom);
    if (wr) begin
      old = mem[adr(wi)];
      mem[adr(wi)] = {mrg(old[35:18], w1, m1), mrg(old[17:0], w0, m0)};
    end
    nxt_e = mem[adr(ri)];
    u_ctrl.cyc(rd, adr(ri), wr, adr(wi), w0, w1, m0, m1);
  endtask

  // read pipeline, slot n holds the read taken n rises ago
  always @(posedge k) begin
    e[2] = e[1];
    e[1] = e[0];
    e[0] = nxt_e;
    v = {v[1:0], !rsel_n};
    #1;
    if (chk) begin
      check(echo, 2'h1);
      check(oe_n, pll_en ? !v[2] : !v[1]);
      if (pll_en ? v[2] : v[1]) check(rdata, pll_en ? e[2][35:18] : e[1][17:0]);
    end
  end
  always @(negedge k) begin
    #1;
    if (chk) begin
      check(echo, 2'h2);
      check(oe_n, !v[1]);
      if (v[1]) check(rdata, pll_en ? e[1][17:0] : e[1][35:18]);
    end
  end

  // spacing of impedance strobes
  always @(negedge clk_i) begin
    gap++;
    if (!reset_n_i) begin
      seen = 1'h0;
    end else if (imp_upd) begin
      if (seen) check(gap, 1024);
      gap = 0;
      seen = 1'h1;
    end
  end

  task automatic wait_lock;
    int n;
    n = 0;
    while (locked !== 1'h1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    check(n >= LC && n <= LC + 10, 1);
  endtask

  task automatic start(input logic pe);
    chk = 1'h0;
    reset_n_i <= 1'h0;
    pll_en <= pe;
    repeat (6) @(posedge clk_i);
    check(oe_n, 1);
    check(locked, 0);
    reset_n_i <= 1'h1;
    if (pe) wait_lock();
    repeat (20) @(posedge clk_i);
    check(single, 1);
    chk = 1'h1;
    $display("test start done");
  endtask

  task automatic traffic(input int n);
    int ri, wi, pr;
    logic rd, wr;
    for (int i = 0; i < 8; i++) begin
      op(1'h0, 0, 1'h1, i, 2'h0, 2'h0);
    end
    op(1'h1, 3, 1'h1, 3, 2'h1, 2'h2);
    op(1'h1, 3, 1'h0, 0, 2'h0, 2'h0);
    op(1'h1, 7, 1'h1, 7, 2'h3, 2'h3);
    pr = 7;
    for (int i = 0; i < n; i++) begin
      rd = 1'($urandom);
      wr = 1'($urandom);
      ri = $urandom % 8;
      wi = $urandom % 8;
      if (wi == pr) wi = wi ^ 1;
      op(rd, ri, wr, wi, 2'($urandom), 2'($urandom));
      pr = rd ? ri : -1;
    end
    repeat (3) op(1'h0, 0, 1'h0, 0, 2'h3, 2'h3);
    $display("test traffic done");
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end
    else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence: pll on, pll restart, pll off
  initial begin
    void'($urandom(32'h12ff_18e5));
    start(1'h1);
    traffic(400);
    chk = 1'h0;
    run = 1'h0;
    repeat (8) @(negedge clk_i);
    check(locked, 0);
    run = 1'h1;
    wait_lock();
    $display("test pll restart done");
    start(1'h0);
    traffic(400);
    report_and_stop();
  end

  // watchdog
  initial begin
    #400_000;
    miscompares++;
    report_and_stop();
  end
endmodule
